// ===== design/rlm_consts.svh
// Purpose: offsets, field positions, reset values and widths of the
//          receive link alarm and error monitor
// Assumes: register indices are word indices; byte address = index * 4
// Notes:   bit positions count from the least significant bit
`ifndef RLM_CONSTS_SVH
`define RLM_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define RLM_IDX_W 18
`define RLM_IDX_SECT_CNT 18'h3_0a09
`define RLM_IDX_CELL_CNT 18'h3_0a0a
`define RLM_IDX_DROP 18'h3_0a0b
`define RLM_IDX_OOS 18'h3_0a0c
`define RLM_IDX_NEARF 18'h3_0a0d
`define RLM_IDX_ALERR 18'h3_0a0e
`define RLM_IDX_CTRL 18'h3_0a10
`define RLM_IDX_IRQ_ST 18'h3_0a11
`define RLM_IDX_IRQ_EN 18'h3_0a12
`define RLM_IDX_IRQ_CLR 18'h3_0a13

// ****************************************************************
// field positions and widths
// ****************************************************************
`define RLM_BIT_GRP_B_DROP 3
`define RLM_BIT_GRP_A_DROP 5
`define RLM_BIT_GRP_B_SONET 2
`define RLM_BIT_GRP_A_SONET 5
`define RLM_BIT_GRP_B_ALERR 3
`define RLM_BIT_GRP_A_ALERR 5
`define RLM_CTRL_CELL_MODE 0
`define RLM_CTRL_SEL_LSB 1
`define RLM_CTRL_MIN_LSB 8
`define RLM_NLINK 8
`define RLM_SEL_W 3
`define RLM_CNT_W 8
`define RLM_PTR_W 8
`define RLM_NIRQ 6

// ****************************************************************
// reset values and constants
// ****************************************************************
`define RLM_CNT_RESET 8'h00
`define RLM_CNT_MAX 8'hff
`define RLM_PTR_ZERO 8'h00
`define RLM_RESP_OKAY 2'h0
`define RLM_RESP_DECERR 2'h3

`endif

// ===== design/rlm_pkg.sv
// Purpose: types of the receive link alarm and error monitor
// Assumes: widths come from rlm_consts.svh
// Notes:   the whole module state is one packed struct
`include "rlm_consts.svh"

package rlm_pkg;

    // ****************************************************************
    // module state
    // ****************************************************************
    typedef struct packed {
        logic awv;
        logic [`RLM_IDX_W-1:0] awidx;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`RLM_CNT_W-1:0] sect_cnt;
        logic [`RLM_CNT_W-1:0] cell_cnt;
        logic [1:0] drop;
        logic [1:0] oos;
        logic [1:0] nearf;
        logic [1:0] alerr;
        logic cell_mode;
        logic [`RLM_SEL_W-1:0] link_sel;
        logic [`RLM_PTR_W-1:0] fifo_min;
        logic [`RLM_NIRQ-1:0] irq_st;
        logic [`RLM_NIRQ-1:0] irq_en;
        logic alarm_a;
        logic alarm_b;
        logic irq;
    } rlm_state_s;

endpackage

// ===== design/rlm_monitor.sv
// Purpose: receive link error counters and group alarm flags with an
//          AXI4-Lite register slave
// Assumes: all event inputs come from receive logic clocked by aclk
// Notes:   group vectors use index 1 for group A (AC/AD) and index 0
//          for group B (BC/BD)
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rlm_consts.svh"

// How it works
// - an 8-bit section parity error count rises on each error of the monitored link and clears when read; an error in the read cycle leaves it at one.
// - an 8-bit cell parity error count rises on each cell error of the monitored link in cell mode and clears when read.
// - the link select setting picks the one link that feeds both counts.
// - in cell mode a dropped cell in group BC/BD sets bit 3 of the drop status.
// - in cell mode a dropped cell in group AC/AD sets bit 5 of the drop status.
// - in SONET mode a failed channel alignment in BC/BD sets bit 2 of the alignment status.
// - in SONET mode a failed channel alignment in AC/AD sets bit 5 of the alignment status.
// - in SONET mode a nearly full alignment FIFO of BC/BD sets bit 2 of the FIFO status.
// - in SONET mode a nearly full alignment FIFO of AC/AD sets bit 5 of the FIFO status.
// - near-full means the read address is below the threshold when the write address zero is written.
// - in cell mode an alignment error between BC and BD sets bit 3 of the alignment error status.
// - in cell mode an alignment error between AC and AD sets bit 5 of the alignment error status.
// - each group alarm is the OR of that group's status bits and drives an alarm output.
module rlm_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [19:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [19:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // per-link parity error pulses
    input wire logic [`RLM_NLINK-1:0] section_parity_error,
    input wire logic [`RLM_NLINK-1:0] cell_parity_error,
    // per-group event pulses, [1] group a, [0] group b
    input wire logic [1:0] cell_dropped,
    input wire logic [1:0] channel_align_fail,
    input wire logic [1:0] bundle_align_error,
    // per-group alignment fifo pointers
    input wire logic [1:0] align_fifo_wr_en,
    input wire logic [`RLM_PTR_W-1:0] align_fifo_wr_addr_a,
    input wire logic [`RLM_PTR_W-1:0] align_fifo_rd_addr_a,
    input wire logic [`RLM_PTR_W-1:0] align_fifo_wr_addr_b,
    input wire logic [`RLM_PTR_W-1:0] align_fifo_rd_addr_b,
    // alarms
    output logic group_a_alarm,
    output logic group_b_alarm,
    output logic irq
);

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic [32:0] rlm_read(
        input logic [`RLM_IDX_W-1:0] idx,
        input rlm_pkg::rlm_state_s s
    );
        logic [32:0] r;
        r = 33'h1_0000_0000;
        unique case (idx)
            `RLM_IDX_SECT_CNT: r[7:0] = s.sect_cnt;
            `RLM_IDX_CELL_CNT: r[7:0] = s.cell_cnt;
            `RLM_IDX_DROP: begin
                r[`RLM_BIT_GRP_A_DROP] = s.drop[1];
                r[`RLM_BIT_GRP_B_DROP] = s.drop[0];
            end
            `RLM_IDX_OOS: begin
                r[`RLM_BIT_GRP_A_SONET] = s.oos[1];
                r[`RLM_BIT_GRP_B_SONET] = s.oos[0];
            end
            `RLM_IDX_NEARF: begin
                r[`RLM_BIT_GRP_A_SONET] = s.nearf[1];
                r[`RLM_BIT_GRP_B_SONET] = s.nearf[0];
            end
            `RLM_IDX_ALERR: begin
                r[`RLM_BIT_GRP_A_ALERR] = s.alerr[1];
                r[`RLM_BIT_GRP_B_ALERR] = s.alerr[0];
            end
            `RLM_IDX_CTRL: begin
                r[`RLM_CTRL_CELL_MODE] = s.cell_mode;
                r[`RLM_CTRL_SEL_LSB +: `RLM_SEL_W] = s.link_sel;
                r[`RLM_CTRL_MIN_LSB +: `RLM_PTR_W] = s.fifo_min;
            end
            `RLM_IDX_IRQ_ST: r[`RLM_NIRQ-1:0] = s.irq_st;
            `RLM_IDX_IRQ_EN: r[`RLM_NIRQ-1:0] = s.irq_en;
            `RLM_IDX_IRQ_CLR: r[31:0] = 32'h0000_0000;
            default: r = 33'h0_0000_0000;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // state and handshakes
    // ****************************************************************
    rlm_pkg::rlm_state_s q;
    rlm_pkg::rlm_state_s d;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic [`RLM_IDX_W-1:0] ar_idx;
    logic [32:0] rd_word;
    logic [32:0] wr_word;
    logic rd_sect;
    logic rd_cell;
    logic rd_drop;
    logic rd_oos;
    logic rd_nearf;
    logic rd_alerr;
    logic sel_sect_err;
    logic sel_cell_err;
    logic [1:0] near_hit;
    logic [`RLM_NIRQ-1:0] irq_evt;

    assign s_axi_awready = !q.awv;
    assign s_axi_wready = !q.wv;
    assign s_axi_arready = !q.rvalid;
    assign aw_hs = s_axi_awvalid && !q.awv;
    assign w_hs = s_axi_wvalid && !q.wv;
    assign ar_hs = s_axi_arvalid && !q.rvalid;
    // the response waits for both halves and a free response slot
    assign wr_go = q.awv && q.wv && !q.bvalid;
    assign ar_idx = s_axi_araddr[19:2];
    assign rd_word = rlm_read(ar_idx, q);
    // the held write address decides the write response
    assign wr_word = rlm_read(q.awidx, q);

    // reads that clear counts and flags
    assign rd_sect = ar_hs && (ar_idx == `RLM_IDX_SECT_CNT);
    assign rd_cell = ar_hs && (ar_idx == `RLM_IDX_CELL_CNT);
    assign rd_drop = ar_hs && (ar_idx == `RLM_IDX_DROP);
    assign rd_oos = ar_hs && (ar_idx == `RLM_IDX_OOS);
    assign rd_nearf = ar_hs && (ar_idx == `RLM_IDX_NEARF);
    assign rd_alerr = ar_hs && (ar_idx == `RLM_IDX_ALERR);

    // ****************************************************************
    // event sources
    // ****************************************************************
    // one link feeds both counters
    assign sel_sect_err = section_parity_error[q.link_sel];
    assign sel_cell_err = cell_parity_error[q.link_sel];

    // near-full is judged only on the write to address zero
    assign near_hit[1] = !q.cell_mode && align_fifo_wr_en[1]
        && (align_fifo_wr_addr_a == `RLM_PTR_ZERO)
        && (align_fifo_rd_addr_a < q.fifo_min);
    assign near_hit[0] = !q.cell_mode && align_fifo_wr_en[0]
        && (align_fifo_wr_addr_b == `RLM_PTR_ZERO)
        && (align_fifo_rd_addr_b < q.fifo_min);

    assign irq_evt = {
        q.cell_mode && |bundle_align_error,
        |near_hit,
        !q.cell_mode && |channel_align_fail,
        q.cell_mode && |cell_dropped,
        q.cell_mode && sel_cell_err,
        sel_sect_err
    };

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        // write channels
        if (aw_hs) begin
            d.awv = 1'b1;
            d.awidx = s_axi_awaddr[19:2];
        end
        if (w_hs) begin
            d.wv = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.awv = 1'b0;
            d.wv = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_word[32] ? `RLM_RESP_OKAY : `RLM_RESP_DECERR;
            if (q.awidx == `RLM_IDX_CTRL && q.wstrb[0]) begin
                d.cell_mode = q.wdata[`RLM_CTRL_CELL_MODE];
                d.link_sel = q.wdata[`RLM_CTRL_SEL_LSB +: `RLM_SEL_W];
            end
            if (q.awidx == `RLM_IDX_CTRL && q.wstrb[1]) begin
                d.fifo_min = q.wdata[`RLM_CTRL_MIN_LSB +: `RLM_PTR_W];
            end
            if (q.awidx == `RLM_IDX_IRQ_EN && q.wstrb[0]) begin
                d.irq_en = q.wdata[`RLM_NIRQ-1:0];
            end
            if (q.awidx == `RLM_IDX_IRQ_CLR && q.wstrb[0]) begin
                d.irq_st = q.irq_st & ~q.wdata[`RLM_NIRQ-1:0];
            end
        end
        // read channels
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rdata = rd_word[31:0];
            d.rresp = rd_word[32] ? `RLM_RESP_OKAY : `RLM_RESP_DECERR;
        end
        // counters: clear first so an error in the read cycle survives
        if (rd_sect) begin
            d.sect_cnt = `RLM_CNT_RESET;
        end
        if (sel_sect_err && d.sect_cnt != `RLM_CNT_MAX) begin
            d.sect_cnt = d.sect_cnt + 8'h01;
        end
        if (rd_cell) begin
            d.cell_cnt = `RLM_CNT_RESET;
        end
        if (q.cell_mode && sel_cell_err
            && d.cell_cnt != `RLM_CNT_MAX) begin
            d.cell_cnt = d.cell_cnt + 8'h01;
        end
        // sticky group flags, set wins over read clear
        if (rd_drop) begin
            d.drop = 2'h0;
        end
        if (q.cell_mode) begin
            d.drop = d.drop | cell_dropped;
        end
        if (rd_oos) begin
            d.oos = 2'h0;
        end
        if (!q.cell_mode) begin
            d.oos = d.oos | channel_align_fail;
        end
        if (rd_nearf) begin
            d.nearf = 2'h0;
        end
        d.nearf = d.nearf | near_hit;
        if (rd_alerr) begin
            d.alerr = 2'h0;
        end
        if (q.cell_mode) begin
            d.alerr = d.alerr | bundle_align_error;
        end
        // interrupt status, set wins over clear
        d.irq_st = d.irq_st | irq_evt;
        d.irq = |(d.irq_st & d.irq_en);
        // group summaries follow the flags they gather
        d.alarm_a = d.drop[1] | d.oos[1]
            | d.nearf[1] | d.alerr[1];
        d.alarm_b = d.drop[0] | d.oos[0]
            | d.nearf[0] | d.alerr[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign group_a_alarm = q.alarm_a;
    assign group_b_alarm = q.alarm_b;
    assign irq = q.irq;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_sect_count;
        sel_sect_err && !rd_sect && q.sect_cnt != `RLM_CNT_MAX;
    endsequence

    sequence s_sect_read;
        rd_sect && !sel_sect_err;
    endsequence

    sequence s_wr_ready;
        q.awv && q.wv && !q.bvalid;
    endsequence

    sequence s_cell_count;
        q.cell_mode && sel_cell_err && !rd_cell
            && q.cell_cnt != `RLM_CNT_MAX;
    endsequence

    AST_SECT_INC: assert property (
        s_sect_count |=> q.sect_cnt == $past(q.sect_cnt) + 8'h01)
        else $error("section count did not step");

    AST_SECT_CLR: assert property (
        s_sect_read |=> q.sect_cnt == 8'h00 ##1 1'b1)
        else $error("section count not cleared by read");

    AST_CELL_INC: assert property (
        s_cell_count |=> q.cell_cnt == $past(q.cell_cnt) + 8'h01)
        else $error("cell count did not step");

    AST_CELL_SAT: assert property (
        q.cell_cnt == 8'hff && !rd_cell |=> q.cell_cnt == 8'hff)
        else $error("cell count wrapped");

    AST_DROP_CLR: assert property (
        rd_drop && !(q.cell_mode && |cell_dropped) |=> q.drop == 2'h0)
        else $error("drop flags not cleared by read");

    AST_CELL_GATE: assert property (
        !q.cell_mode && !rd_cell |=> $stable(q.cell_cnt))
        else $error("cell count moved outside cell mode");

    AST_SEL_LINK: assert property (
        !sel_sect_err && !rd_sect |=> $stable(q.sect_cnt))
        else $error("count moved without selected link error");

    AST_SATURATE: assert property (
        q.sect_cnt == 8'hff && !rd_sect |=> q.sect_cnt == 8'hff)
        else $error("section count wrapped");

    AST_DROP_SET: assert property (
        q.cell_mode && |cell_dropped
        |=> (q.drop & $past(cell_dropped)) == $past(cell_dropped))
        else $error("cell drop flag missed");

    AST_OOS_SET: assert property (
        !q.cell_mode && |channel_align_fail
        |=> (q.oos & $past(channel_align_fail)) == $past(channel_align_fail))
        else $error("alignment flag missed");

    AST_NEARF_SET: assert property (
        |near_hit |=> (q.nearf & $past(near_hit)) == $past(near_hit))
        else $error("near full flag missed");

    AST_NEARF_ONLY: assert property (
        !rd_nearf && !(|near_hit) |=> $stable(q.nearf))
        else $error("near full flag moved without cause");

    AST_ALERR_SET: assert property (
        q.cell_mode && |bundle_align_error
        |=> (q.alerr & $past(bundle_align_error)) == $past(bundle_align_error))
        else $error("bundle alignment flag missed");

    AST_ALARM: assert property (
        group_a_alarm == |{q.drop[1], q.oos[1], q.nearf[1], q.alerr[1]}
        && group_b_alarm == |{q.drop[0], q.oos[0], q.nearf[0], q.alerr[0]})
        else $error("group alarm does not match flags");

    AST_BRESP: assert property (
        s_wr_ready |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response missing");

endmodule

// ===== tb/rlm_link_model.sv
// Purpose: far-side model of the receive links and alignment fifos
// Assumes: each event is a one-cycle pulse launched after a rising edge
// Notes:   fifo addresses idle at the inverse of the last value
`timescale 1ns/1ps

module rlm_link_model (
    // clock
    input wire logic aclk,
    // link and group events
    output logic [7:0] section_parity_error,
    output logic [7:0] cell_parity_error,
    output logic [1:0] cell_dropped,
    output logic [1:0] channel_align_fail,
    output logic [1:0] bundle_align_error,
    // alignment fifo strobes and addresses
    output logic [1:0] align_fifo_wr_en,
    output logic [7:0] align_fifo_wr_addr_a,
    output logic [7:0] align_fifo_rd_addr_a,
    output logic [7:0] align_fifo_wr_addr_b,
    output logic [7:0] align_fifo_rd_addr_b
);
    logic [23:0] ev_q = 24'h00_0000;
    logic [31:0] ptr_q = 32'h5a5a_a5a5;

    assign {section_parity_error, cell_parity_error, cell_dropped,
        channel_align_fail, bundle_align_error, align_fifo_wr_en} = ev_q;
    assign {align_fifo_wr_addr_a, align_fifo_rd_addr_a,
        align_fifo_wr_addr_b, align_fifo_rd_addr_b} = ptr_q;

    // ********
    // one event cycle then one quiet cycle, so pulses never merge
    // ********
    task automatic drive(input logic [23:0] ev, input logic [31:0] ptr);
        ev_q <= ev;
        ptr_q <= ptr;
        @(posedge aclk);
        ev_q <= 24'h00_0000;
        // stale addresses would hide a missing write-strobe check
        ptr_q <= ~ptr;
        @(posedge aclk);
    endtask
endmodule

// ===== tb/rlm_monitor_tb.sv
// Purpose: self-checking bench of the receive link alarm monitor
// Assumes: one aclk domain, axi4-lite master per the hand-over timing
// Notes:   an integer model predicts every read value and alarm pin
`timescale 1ns/1ps
`include "rlm_consts.svh"

module rlm_monitor_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [19:0] s_axi_awaddr = 20'h0_0000, s_axi_araddr = 20'h0_0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] section_parity_error, cell_parity_error;
    logic [1:0] cell_dropped, channel_align_fail, bundle_align_error;
    logic [1:0] align_fifo_wr_en;
    logic [7:0] align_fifo_wr_addr_a, align_fifo_rd_addr_a;
    logic [7:0] align_fifo_wr_addr_b, align_fifo_rd_addr_b;
    logic group_a_alarm, group_b_alarm, irq;
    int bad_count = 0, n_checks = 0;
    int sect_m = 0, cell_m = 0, irq_m = 0, mode_m = 0, sel_m = 0, min_m = 0;
    int flag_m[4] = '{0, 0, 0, 0};
    int pos_b[4] = '{3, 2, 2, 3};
    int seed;

    rlm_monitor uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .section_parity_error, .cell_parity_error,
        .cell_dropped, .channel_align_fail, .bundle_align_error,
        .align_fifo_wr_en, .align_fifo_wr_addr_a, .align_fifo_rd_addr_a,
        .align_fifo_wr_addr_b, .align_fifo_rd_addr_b, .group_a_alarm,
        .group_b_alarm, .irq);
    rlm_link_model links (.aclk, .section_parity_error, .cell_parity_error,
        .cell_dropped, .channel_align_fail, .bundle_align_error,
        .align_fifo_wr_en, .align_fifo_wr_addr_a, .align_fifo_rd_addr_a,
        .align_fifo_wr_addr_b, .align_fifo_rd_addr_b);

    always #2 aclk = ~aclk;

    // ********
    // compares and bus cycles
    // ********
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [17:0] idx, input logic [31:0] d,
        input logic [1:0] er = `RLM_RESP_OKAY);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {idx, 2'b00, d, 4'hf};
        s_axi_awprot <= 3'($urandom);
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        cmp_val({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic chk_rd(input logic [17:0] idx, input logic [31:0] exp,
        input logic [1:0] er = `RLM_RESP_OKAY);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arprot <= 3'($urandom);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        cmp_val(s_axi_rdata, exp);
        cmp_val({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // ********
    // reference model
    // ********
    task automatic set_ctrl(input int m, input int s, input int mn);
        mode_m = m;
        sel_m = s;
        min_m = mn;
        axi_wr(`RLM_IDX_CTRL, 32'(mn * 256 + s * 2 + m));
        chk_rd(`RLM_IDX_CTRL, 32'(mn * 256 + s * 2 + m));
    endtask

    task automatic ev(input logic [7:0] s, c, input logic [1:0] d, f, b,
        we, input logic [31:0] p);
        logic [3:0] hit;
        logic [7:0] wa, ra;
        links.drive({s, c, d, f, b, we}, p);
        if (s[sel_m]) sect_m = (sect_m < 255) ? sect_m + 1 : 255;
        if (c[sel_m] && mode_m) cell_m = (cell_m < 255) ? cell_m + 1 : 255;
        irq_m |= {c[sel_m] && mode_m, s[sel_m]};
        for (int g = 0; g < 2; g++) begin
            wa = p[16 * g + 8 +: 8];
            ra = p[16 * g +: 8];
            hit = {b[g] && mode_m, we[g] && !mode_m && wa == 8'h00 &&
                ra < min_m, f[g] && !mode_m, d[g] && mode_m};
            for (int k = 0; k < 4; k++) begin
                if (hit[k]) begin
                    flag_m[k] |= 1 << (g ? 5 : pos_b[k]);
                    irq_m |= 1 << (k + 2);
                end
            end
        end
    endtask

    function automatic logic alarm_m(input int g);
        logic a;
        a = 1'b0;
        for (int k = 0; k < 4; k++) a |= flag_m[k][g ? 5 : pos_b[k]];
        return a;
    endfunction

    task automatic chk_pins();
        cmp_pin(group_a_alarm, alarm_m(1));
        cmp_pin(group_b_alarm, alarm_m(0));
    endtask

    // every read clears the counts and flags it returns
    task automatic rd_all();
        chk_rd(`RLM_IDX_SECT_CNT, sect_m);
        chk_rd(`RLM_IDX_CELL_CNT, cell_m);
        for (int k = 0; k < 4; k++) chk_rd(18'(`RLM_IDX_DROP + k), flag_m[k]);
        {sect_m, cell_m} = 64'h0;
        flag_m = '{0, 0, 0, 0};
    endtask

    initial begin
        #40000;
        bad_count++;
        stop_test();
    end

    initial begin
        logic [1:0] gm, ri;
        seed = $urandom(32'h4473);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // index 0x30a0f between the two banks is unmapped
        for (int i = 0; i < 11; i++) begin
            ri = (i == 6) ? `RLM_RESP_DECERR : `RLM_RESP_OKAY;
            chk_rd(18'(`RLM_IDX_SECT_CNT + i), 32'h0, ri);
        end
        axi_wr(18'h0_0100, 32'hffff_ffff, `RLM_RESP_DECERR);
        axi_wr(`RLM_IDX_SECT_CNT, 32'h0000_00ff);
        for (int i = 0; i < 8; i++) begin
            set_ctrl(i % 2, i, 0);
            repeat (20 + $urandom_range(20)) ev(8'($urandom), 8'($urandom),
                2'h0, 2'h0, 2'h0, 2'h0, 32'($urandom));
            rd_all();
            rd_all();
        end
        set_ctrl(1, 5, 0);
        repeat (300) ev(8'h20, 8'h20, 2'h0, 2'h0, 2'h0, 2'h0, 32'h0);
        rd_all();
        for (int m = 0; m < 2; m++) begin
            set_ctrl(m, 0, 8'h10);
            for (int g = 0; g < 2; g++) begin
                gm = 2'(1 << g);
                ev(8'h00, 8'h00, gm, gm, gm, gm, 32'h000f_000f);
                chk_pins();
                rd_all();
                chk_pins();
            end
        end
        set_ctrl(0, 0, 8'h10);
        ev(8'h00, 8'h00, 2'h0, 2'h0, 2'h0, 2'h3, 32'h000f_0010);
        rd_all();
        ev(8'h00, 8'h00, 2'h0, 2'h0, 2'h0, 2'h3, 32'h0100_000f);
        ev(8'h00, 8'h00, 2'h0, 2'h0, 2'h0, 2'h0, 32'h0000_0000);
        rd_all();
        chk_rd(`RLM_IDX_IRQ_ST, irq_m);
        cmp_pin(irq, 1'b0);
        axi_wr(`RLM_IDX_IRQ_EN, 32'h0000_003f);
        repeat (2) @(posedge aclk);
        cmp_pin(irq, irq_m != 0);
        axi_wr(`RLM_IDX_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        cmp_pin(irq, 1'b0);
        axi_wr(`RLM_IDX_IRQ_EN, 32'h0000_003f);
        axi_wr(`RLM_IDX_IRQ_CLR, 32'h0000_003f);
        irq_m = 0;
        repeat (2) @(posedge aclk);
        cmp_pin(irq, 1'b0);
        chk_rd(`RLM_IDX_IRQ_ST, 32'h0);
        chk_rd(`RLM_IDX_IRQ_EN, 32'h0000_003f);
        stop_test();
    end
endmodule
